// >>> fss_pkg.sv
// Constants for the fast sample streamer: register map, fields,
// reset values and timing counts. Assumes a 20 MHz system clock.
package fss_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned START_DELAY_MS  = 500;
    localparam int unsigned START_DELAY_CYC = CLK_HZ / 1000 * START_DELAY_MS;
    localparam int unsigned FULL_POWER_RESET_CMD_HOLD_S     = 5;
    localparam int unsigned FULL_POWER_RESET_CMD_HOLD_CYC   = CLK_HZ * FULL_POWER_RESET_CMD_HOLD_S;
    localparam int unsigned MAX_RATE_HZ     = 512;
    localparam int unsigned MIN_PERIOD_CYC  = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam int unsigned SER_BAUD        = 115200;
    localparam int unsigned SER_CHAR_BITS   = 10;
    localparam int unsigned SER_BYTE_CYC    = CLK_HZ / SER_BAUD * SER_CHAR_BITS;
    localparam int unsigned TIMER_W         = 27;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_OUTSEL = 8'h04;
    localparam logic [7:0] OFS_CMD    = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_ERR    = 8'h10;
    localparam logic [7:0] OFS_RATE   = 8'h14;
    localparam logic [7:0] OFS_OFSX   = 8'h18;
    localparam logic [7:0] OFS_OFSY   = 8'h1C;
    localparam logic [7:0] OFS_RATIO  = 8'h20;
    localparam logic [7:0] OFS_ID     = 8'h24;

    // CTRL fields
    localparam int CTRL_FAST = 0;
    localparam int CTRL_EXP  = 1;
    localparam int CTRL_LOOP = 3;
    // CMD fields, write one to issue
    localparam int CMD_DSTART = 0;
    localparam int CMD_ISTART = 1;
    localparam int CMD_PAUSE  = 2;
    localparam int CMD_CFGRST = 3;
    localparam int CMD_FULL_POWER_RESET_CMD   = 4;
    localparam int CMD_BREAD  = 5;
    // STATUS fields
    localparam int ST_IFRDY  = 0;
    localparam int ST_STORE  = 1;
    localparam int ST_PEND   = 2;
    localparam int ST_BREAD  = 3;
    localparam int ST_FULL_POWER_RESET_CMD   = 4;
    localparam int ST_COUNT  = 8;
    // ERR fields
    localparam int ERR_OVR = 0;

    // Reset values
    localparam logic [15:0] RATIO_ONE   = 16'h1000;
    localparam int          RATIO_SHIFT = 12;
    localparam logic [1:0]  EXP_X1      = 2'h0;
    localparam logic [1:0]  EXP_X10     = 2'h1;
    localparam logic        OUT_PAR     = 1'b0;
    localparam logic [31:0] DEVICE_ID   = 32'h5A3C_0001; // Arbitrary value

    // Scaling: code 29788 is full scale
    localparam logic signed [47:0] FULL_SCALE_CODE = 48'sd29788;
    localparam int                 FRAC_SHIFT      = 15;
    localparam logic signed [47:0] MUL_X1   = 48'sd1;
    localparam logic signed [47:0] MUL_X10  = 48'sd10;
    localparam logic signed [47:0] MUL_X100 = 48'sd100;
    localparam logic signed [47:0] SAT_MAX  = 48'sd32767;
    localparam logic signed [47:0] SAT_MIN  = -48'sd32768;
endpackage

// >>> fss_timer.sv
// Loadable down counter; done is high in the last counted cycle.
// Assumes load and load_val come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module fss_timer #(
    parameter int W = 27
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next = load ? load_val : (busy ? cnt_reg - W'(1) : cnt_reg);
    assign busy     = (cnt_reg != '0);
    assign done     = (cnt_reg == W'(1));

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// >>> fast_sample_streamer.sv
// Fast sample streamer: stores adjusted X/Y samples and streams them
// to the parallel bus listener; binary buffer dump on the serial port.
// Assumes MEAS_X/MEAS_Y on CLK; GPIB_READY and GPIB_TALK from pins.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fast_sample_streamer
    import fss_pkg::*;
#(
    parameter int DEPTH             = 16,
    parameter int START_DELAY_CYCLES = START_DELAY_CYC,
    parameter int FULL_POWER_RESET_CMD_HOLD_CYCLES   = FULL_POWER_RESET_CMD_HOLD_CYC,
    parameter int MIN_PERIOD_CYCLES  = MIN_PERIOD_CYC
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [15:0] MEAS_X,
    input  wire logic [15:0] MEAS_Y,
    input  wire logic        GPIB_READY,
    input  wire logic        GPIB_TALK,
    output logic      [7:0]  GPIB_DATA,
    output logic             GPIB_VALID,
    output logic      [7:0]  SER_DATA,
    output logic             SER_STROBE,
    output logic             DSP_RELOAD
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = TIMER_W;

    // Bus slave state
    logic [7:0]  a_reg;
    logic        wr_pend_reg, rd_pend_reg, rdy_reg, resp_reg;
    logic [31:0] hrdata_reg;
    // Configuration
    logic        fast_reg, loop_reg, outsel_reg, ovr_reg;
    logic [1:0]  exp_reg;
    logic [TW-1:0] rate_reg;
    logic [15:0] ofsx_reg, ofsy_reg, ratio_reg;
    // Storage
    logic [31:0] buf_reg [DEPTH];
    logic [AW-1:0] head_reg;
    logic [AW:0] cnt_reg;
    logic        store_reg, pend_reg;
    // Parallel framer
    logic [31:0] gsh_reg;
    logic [2:0]  gleft_reg;
    logic [7:0]  gdata_reg;
    logic        gvalid_reg;
    // Serial dump
    logic [31:0] ssh_reg;
    logic [AW-1:0] sptr_reg;
    logic [AW:0] sleft_reg;
    logic [1:0]  sbyte_reg;
    logic        sbusy_reg, sstb_reg, reload_reg;
    logic [7:0]  sdata_reg;
    // Pin synchronisers
    logic [1:0]  rdy_sync_reg, talk_sync_reg;

    // Decode
    wire         addr_ok  = HSEL & HREADY & HTRANS[1];
    wire         full_power_reset_cmd_busy;
    wire         we       = wr_pend_reg & ~full_power_reset_cmd_busy;
    wire         w_ctrl   = we & (a_reg == OFS_CTRL);
    wire         w_out    = we & (a_reg == OFS_OUTSEL);
    wire         w_cmd    = we & (a_reg == OFS_CMD);
    wire         w_err    = we & (a_reg == OFS_ERR);
    wire         w_rate   = we & (a_reg == OFS_RATE);
    wire         c_dstart = w_cmd & HWDATA[CMD_DSTART];
    wire         c_istart = w_cmd & HWDATA[CMD_ISTART];
    wire         c_pause  = w_cmd & HWDATA[CMD_PAUSE];
    wire         c_full_power_reset_cmd   = w_cmd & HWDATA[CMD_FULL_POWER_RESET_CMD];
    wire         cfg_rst  = SYS_RST | c_full_power_reset_cmd | (w_cmd & HWDATA[CMD_CFGRST]);
    wire         com_rst  = SYS_RST | c_full_power_reset_cmd;
    wire         c_bread  = w_cmd & HWDATA[CMD_BREAD] & ~sbusy_reg & (cnt_reg != '0);
    wire         rdy_s    = rdy_sync_reg[1];
    wire         talk_s   = talk_sync_reg[1];
    wire         iface_rdy = ~sbusy_reg & ~full_power_reset_cmd_busy;

    // Timers
    wire rate_done, start_busy, start_done, byte_done;
    wire tick = start_done | (store_reg & rate_done) | c_istart;
    wire full = (cnt_reg == (AW+1)'(DEPTH));
    wire store_ok = tick & (~full | loop_reg);
    wire fast_path = fast_reg & ~outsel_reg;
    wire stream_go = store_ok & fast_path;
    wire overrun = stream_go & ((gleft_reg != '0) | ~rdy_s | ~talk_s);
    wire gsend = (gleft_reg != '0) & rdy_s;
    wire semit = sbusy_reg & byte_done;
    wire [TW-1:0] rate_w = (HWDATA[TW-1:0] < TW'(MIN_PERIOD_CYCLES))
                           ? TW'(MIN_PERIOD_CYCLES) : HWDATA[TW-1:0];

    fss_timer #(.W(TW)) u_rate (
        .clk(CLK), .rst(cfg_rst), .load(tick), .load_val(rate_reg),
        .busy(), .done(rate_done));
    fss_timer #(.W(TW)) u_start (
        .clk(CLK), .rst(cfg_rst), .load(c_dstart),
        .load_val(TW'(START_DELAY_CYCLES)), .busy(start_busy), .done(start_done));
    fss_timer #(.W(TW)) u_full_power_reset_cmd (
        .clk(CLK), .rst(SYS_RST), .load(c_full_power_reset_cmd),
        .load_val(TW'(FULL_POWER_RESET_CMD_HOLD_CYCLES)), .busy(full_power_reset_cmd_busy), .done());
    fss_timer #(.W(TW)) u_byte (
        .clk(CLK), .rst(com_rst), .load(c_bread | semit),
        .load_val(c_bread ? TW'(1) : TW'(SER_BYTE_CYC)), .busy(), .done(byte_done));

    // Offset, ratio, expand, then scale to full-scale code
    function automatic logic [15:0] adjust(input logic [15:0] raw, input logic [15:0] ofs,
                                           input logic [15:0] ratio, input logic [1:0] esel);
        logic signed [47:0] v;
        logic signed [47:0] m;
        v = 48'(signed'(raw)) - 48'(signed'(ofs));
        v = (v * signed'(48'(ratio))) >>> RATIO_SHIFT;
        m = (esel == EXP_X1) ? MUL_X1 : ((esel == EXP_X10) ? MUL_X10 : MUL_X100);
        v = ((v * m) * FULL_SCALE_CODE) >>> FRAC_SHIFT;
        if (v > SAT_MAX) begin
            adjust = 16'h7FFF;
        end else if (v < SAT_MIN) begin
            adjust = 16'h8000;
        end else begin
            adjust = v[15:0];
        end
    endfunction

    wire [31:0] sample = {adjust(MEAS_X, ofsx_reg, ratio_reg, exp_reg),
                          adjust(MEAS_Y, ofsy_reg, ratio_reg, exp_reg)};
    wire [AW-1:0] wr_idx = head_reg + cnt_reg[AW-1:0];

    wire [31:0] status = {16'h0000, (8-AW-1)'(0), cnt_reg, 3'h0, full_power_reset_cmd_busy,
                          sbusy_reg, start_busy, store_reg, iface_rdy};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (a_reg)
            OFS_CTRL:   rd_mux = {28'h0, loop_reg, exp_reg, fast_reg};
            OFS_OUTSEL: rd_mux = {31'h0, outsel_reg};
            OFS_STATUS: rd_mux = status;
            OFS_ERR:    rd_mux = {31'h0, ovr_reg};
            OFS_RATE:   rd_mux = 32'(rate_reg);
            OFS_OFSX:   rd_mux = {16'h0, ofsx_reg};
            OFS_OFSY:   rd_mux = {16'h0, ofsy_reg};
            OFS_RATIO:  rd_mux = {16'h0, ratio_reg};
            OFS_ID:     rd_mux = DEVICE_ID;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus slave: writes zero wait, reads one wait
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            a_reg       <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rdy_reg     <= 1'b1;
            resp_reg    <= 1'b0;
            hrdata_reg  <= 32'h0000_0000;
        end else begin
            if (addr_ok) begin
                a_reg <= HADDR[7:0];
            end
            wr_pend_reg <= addr_ok & HWRITE;
            rd_pend_reg <= addr_ok & ~HWRITE;
            rdy_reg     <= ~(addr_ok & ~HWRITE);
            if (rd_pend_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (cfg_rst) begin
            fast_reg  <= 1'b0;
            loop_reg  <= 1'b0;
            exp_reg   <= EXP_X1;
            ovr_reg   <= 1'b0;
            rate_reg  <= TW'(MIN_PERIOD_CYCLES);
            ofsx_reg  <= 16'h0000;
            ofsy_reg  <= 16'h0000;
            ratio_reg <= RATIO_ONE;
        end else begin
            if (overrun || (w_out && HWDATA[0])) begin
                fast_reg <= 1'b0;
            end else if (w_ctrl) begin
                fast_reg <= HWDATA[CTRL_FAST] & ~outsel_reg;
            end
            if (w_ctrl) begin
                exp_reg  <= HWDATA[CTRL_EXP+1:CTRL_EXP];
                loop_reg <= HWDATA[CTRL_LOOP];
            end
            // Set wins over write-one-clear
            ovr_reg <= overrun | (ovr_reg & ~(w_err & HWDATA[ERR_OVR]));
            if (w_rate) begin
                rate_reg <= rate_w;
            end
            if (we && a_reg == OFS_OFSX) begin
                ofsx_reg <= HWDATA[15:0];
            end
            if (we && a_reg == OFS_OFSY) begin
                ofsy_reg <= HWDATA[15:0];
            end
            if (we && a_reg == OFS_RATIO) begin
                ratio_reg <= HWDATA[15:0];
            end
        end
    end

    // Storage control and buffer
    always_ff @(posedge CLK) begin
        if (cfg_rst) begin
            store_reg <= 1'b0;
            pend_reg  <= 1'b0;
            head_reg  <= '0;
            cnt_reg   <= '0;
        end else begin
            pend_reg <= c_dstart | (pend_reg & ~start_done);
            if (c_pause || (tick && full && !loop_reg)) begin
                store_reg <= 1'b0;
            end else if (start_done || c_istart) begin
                store_reg <= 1'b1;
            end
            if (store_ok && !full) begin
                cnt_reg <= cnt_reg + (AW+1)'(1);
            end else if (store_ok) begin
                head_reg <= head_reg + AW'(1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (store_ok) begin
            buf_reg[wr_idx] <= sample;
        end
    end

    // Pin synchronisers and parallel framer
    always_ff @(posedge CLK) begin
        if (com_rst) begin
            outsel_reg    <= OUT_PAR;
            rdy_sync_reg  <= 2'b00;
            talk_sync_reg <= 2'b00;
            gleft_reg     <= 3'h0;
            gsh_reg       <= 32'h0000_0000;
            gdata_reg     <= 8'h00;
            gvalid_reg    <= 1'b0;
        end else begin
            if (w_out) begin
                outsel_reg <= HWDATA[0];
            end
            rdy_sync_reg  <= {rdy_sync_reg[0], GPIB_READY};
            talk_sync_reg <= {talk_sync_reg[0], GPIB_TALK};
            gvalid_reg    <= gsend;
            if (gsend) begin
                gdata_reg <= gsh_reg[31:24];
                gsh_reg   <= {gsh_reg[23:0], 8'h00};
                gleft_reg <= gleft_reg - 3'h1;
            end else if (stream_go && !overrun) begin
                gsh_reg   <= sample;
                gleft_reg <= 3'h4;
            end
        end
    end

    // Serial binary buffer dump, raw bytes with no gaps
    always_ff @(posedge CLK) begin
        if (com_rst || cfg_rst) begin
            sbusy_reg  <= 1'b0;
            sstb_reg   <= 1'b0;
            sdata_reg  <= 8'h00;
            ssh_reg    <= 32'h0000_0000;
            sptr_reg   <= '0;
            sleft_reg  <= '0;
            sbyte_reg  <= 2'h0;
            reload_reg <= c_full_power_reset_cmd;
        end else begin
            reload_reg <= 1'b0;
            sstb_reg   <= semit;
            if (c_bread) begin
                sbusy_reg <= 1'b1;
                ssh_reg   <= buf_reg[head_reg];
                sptr_reg  <= head_reg + AW'(1);
                sleft_reg <= cnt_reg - (AW+1)'(1);
                sbyte_reg <= 2'h0;
            end else if (semit) begin
                sdata_reg <= ssh_reg[31:24];
                sbyte_reg <= sbyte_reg + 2'h1;
                if (sbyte_reg != 2'h3) begin
                    ssh_reg <= {ssh_reg[23:0], 8'h00};
                end else if (sleft_reg == '0) begin
                    sbusy_reg <= 1'b0;
                end else begin
                    ssh_reg   <= buf_reg[sptr_reg];
                    sptr_reg  <= sptr_reg + AW'(1);
                    sleft_reg <= sleft_reg - (AW+1)'(1);
                end
            end
        end
    end

    assign HRDATA     = hrdata_reg;
    assign HREADYOUT  = rdy_reg;
    assign HRESP      = resp_reg;
    assign GPIB_DATA  = gdata_reg;
    assign GPIB_VALID = gvalid_reg;
    assign SER_DATA   = sdata_reg;
    assign SER_STROBE = sstb_reg;
    assign DSP_RELOAD = reload_reg;

    // Checks
    logic [TW-1:0] pcnt_reg;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pcnt_reg <= '0;
        end else begin
            pcnt_reg <= pend_reg ? pcnt_reg + TW'(1) : '0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_fast_write: assert property (w_ctrl && !overrun |=>
        fast_reg == ($past(HWDATA[CTRL_FAST]) && !$past(outsel_reg)))
        else $error("fast mode bit not taken");
    chk_stream_load: assert property (stream_go && !overrun |=> gleft_reg == 3'h4)
        else $error("stored sample not framed");
    chk_rate_floor: assert property (rate_reg >= TW'(MIN_PERIOD_CYCLES))
        else $error("sample period below limit");
    chk_no_serial: assert property (outsel_reg |-> !fast_reg)
        else $error("streaming on serial port");
    chk_msb_first: assert property (gsend |=> GPIB_VALID && GPIB_DATA == $past(gsh_reg[31:24]))
        else $error("byte order wrong");
    chk_overrun_stop: assert property (overrun |=> !fast_reg && ovr_reg)
        else $error("overrun not handled");
    chk_start_delay: assert property ($fell(pend_reg) && store_reg |->
        pcnt_reg == TW'(START_DELAY_CYCLES))
        else $error("start delay wrong");
    chk_bread_ready: assert property ($rose(status[ST_IFRDY]) && !$past(cfg_rst) &&
        !$past(full_power_reset_cmd_busy) |-> $past(semit) && $past(sbyte_reg) == 2'h3 && $past(sleft_reg) == '0)
        else $error("ready set before dump end");
    chk_cfg_abort: assert property (w_cmd && HWDATA[CMD_CFGRST] && !c_full_power_reset_cmd |=>
        !store_reg && cnt_reg == '0 && outsel_reg == $past(outsel_reg))
        else $error("config reset incomplete");
    chk_full_power_reset_cmd_ignore: assert property (full_power_reset_cmd_busy && wr_pend_reg |=>
        $stable(rate_reg) && $stable(fast_reg) && $stable(outsel_reg) && $stable(ofsx_reg))
        else $error("command taken during hold");
    chk_id_read: assert property (rd_pend_reg && a_reg == OFS_ID |=> HRDATA == DEVICE_ID)
        else $error("identification wrong");

    cov_overrun: cover property (overrun);
    cov_frame: cover property (gsend && gleft_reg == 3'h1);
    cov_dump_end: cover property ($fell(sbusy_reg));
    cov_delayed: cover property (start_done);
endmodule
`default_nettype wire

// >>> gpib_listener.sv
// Behavioural bus controller acting as listener for the streamed frames.
// Assumes the testbench raises stall to model a listener that cannot keep up.
`timescale 1ns/1ps
`default_nettype none
module gpib_listener (
    input  wire logic CLK,
    input  wire logic stall,
    output logic      ready,
    output logic      talk
);
    initial begin
        ready = 1'b0;
        talk  = 1'b0;
    end
    // Device addressed as talker at once, ready unless told to stall
    always @(posedge CLK) begin
        talk  <= 1'b1;
        ready <= !stall;
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: AHB-Lite master, queued stream byte checks.
// Assumes fss_pkg and the listener model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench import fss_pkg::*; ;
    logic        CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, stall = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rdat;
    logic [1:0]  HTRANS = 2'h0;
    logic [15:0] MEAS_X = 16'h0, MEAS_Y = 16'h0;
    wire  [31:0] HRDATA;
    wire  [7:0]  GPIB_DATA, SER_DATA;
    wire         HREADYOUT, HRESP, GPIB_VALID, SER_STROBE, DSP_RELOAD, rdy, tlk;
    int          err_total = 0, checks = 0, nbyte = 0, reloads = 0, n, x, y, ox, oy, r;
    int          sn = 0, x2, x3;
    time         t_cmd, ser_t;
    time         frame_t[$];
    logic [7:0]  exp_q[$];
    logic [7:0]  ser_q[$];

    fast_sample_streamer #(.START_DELAY_CYCLES(50), .FULL_POWER_RESET_CMD_HOLD_CYCLES(40),
        .MIN_PERIOD_CYCLES(20)) u_fast_sample_streamer (
        .CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEAS_X(MEAS_X),
        .MEAS_Y(MEAS_Y), .GPIB_READY(rdy), .GPIB_TALK(tlk), .GPIB_DATA(GPIB_DATA),
        .GPIB_VALID(GPIB_VALID), .SER_DATA(SER_DATA), .SER_STROBE(SER_STROBE),
        .DSP_RELOAD(DSP_RELOAD));
    gpib_listener u_gpib_listener (.CLK(CLK), .stall(stall), .ready(rdy), .talk(tlk));

    initial begin
        forever #25 CLK = ~CLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (HREADYOUT !== 1'b1 && k < 100);
        if (k >= 100) begin
            err_total++;
            summarize();
        end
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR  <= {24'h0, a};
        wait_rdy();
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        rdat = HRDATA;
        chk(HRESP, 32'h0, "response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp, what);
    endtask

    // Expected 16-bit code for one value; both bytes are queued MSB first
    task automatic note(input logic ser, input logic [15:0] w);
        if (ser) begin
            ser_q.push_back(w[15:8]);
            ser_q.push_back(w[7:0]);
        end else begin
            exp_q.push_back(w[15:8]);
            exp_q.push_back(w[7:0]);
        end
    endtask

    function automatic logic [15:0] scale(input int raw, input int ofs, input int rt,
                                          input int e);
        longint v;
        v = (((longint'(raw - ofs) * rt) >>> 12) * e * 29788) >>> 15;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction

    // Stream monitor: oldest note against each byte, frame start times
    always @(posedge CLK) begin
        if (GPIB_VALID === 1'b1) begin
            if (nbyte % 4 == 0) frame_t.push_back($time);
            nbyte++;
            if (exp_q.size() == 0) chk(GPIB_DATA, 8'hXX, "unexpected byte");
            else chk(GPIB_DATA, exp_q.pop_front(), "stream byte");
        end
        if (SER_STROBE === 1'b1) begin
            if (sn > 0) chk(32'($time - ser_t), SER_BYTE_CYC * 50, "byte gap");
            ser_t = $time;
            sn++;
            if (ser_q.size() == 0) chk(SER_DATA, 8'hXX, "unexpected serial");
            else chk(SER_DATA, ser_q.pop_front(), "serial byte");
        end
        if (DSP_RELOAD === 1'b1) reloads++;
    end

    initial begin
        #(100000 * 50);
        err_total++;
        summarize();
    end

    initial begin
        x = $urandom(32'h0e5add8c);
        x = $urandom_range(60000) - 30000;
        y = $urandom_range(60000) - 30000;
        ox = $urandom_range(511) - 256;
        oy = $urandom_range(511) - 256;
        r = $urandom_range(32'h1000, 32'h0800);
        x2 = $urandom_range(6000) - 3000;
        x3 = $urandom_range(6000) - 3000;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        MEAS_X <= x[15:0];
        MEAS_Y <= y[15:0];
        @(posedge CLK);
        rd(OFS_ID, DEVICE_ID, "id");
        rd(8'h3C, 32'h0, "unmapped");
        rd(OFS_RATIO, {16'h0, RATIO_ONE}, "ratio reset");
        xfer(1'b1, OFS_OFSX, {16'h0, ox[15:0]});
        xfer(1'b1, OFS_OFSY, {16'h0, oy[15:0]});
        xfer(1'b1, OFS_RATIO, r);
        xfer(1'b1, OFS_RATE, 32'h5);
        xfer(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1, "fast on");
        repeat (3) begin
            note(1'b0, scale(x, ox, r, 1));
            note(1'b0, scale(y, oy, r, 1));
        end
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_DSTART);
        t_cmd = $time;
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin
            @(posedge CLK);
            n++;
        end
        stall <= 1'b1;
        chk(n < 2000, 1'b1, "stream done");
        if (frame_t.size() >= 3) begin
            chk(frame_t[0] - t_cmd >= 50 * 50, 1'b1, "start delay");
            chk(frame_t[1] - frame_t[0], 20 * 50, "period 1");
            chk(frame_t[2] - frame_t[1], 20 * 50, "period 2");
        end
        repeat (60) @(posedge CLK);
        rd(OFS_CTRL, 32'h0, "fast off");
        rd(OFS_ERR, 32'h1, "overrun");
        chk(nbyte, 12, "byte count");
        xfer(1'b1, OFS_OUTSEL, 32'h1);
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_CFGRST);
        rd(OFS_OUTSEL, 32'h1, "comms kept");
        rd(OFS_RATIO, {16'h0, RATIO_ONE}, "ratio default");
        rd(OFS_OFSX, 32'h0, "offset default");
        rd(OFS_STATUS, 32'h1, "scan aborted");
        // Two points in loop mode at x10, then paused and dumped on the serial port
        xfer(1'b1, OFS_CTRL, (32'h1 << CTRL_LOOP) | (32'(EXP_X10) << CTRL_EXP));
        rd(OFS_CTRL, 32'hA, "loop x10 mode");
        note(1'b1, scale(x2, 0, 32'h1000, 10));
        note(1'b1, scale(y, 0, 32'h1000, 10));
        note(1'b1, scale(x3, 0, 32'h1000, 10));
        note(1'b1, scale(y, 0, 32'h1000, 10));
        MEAS_X <= x2[15:0];
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_ISTART);
        repeat (10) @(posedge CLK);
        MEAS_X <= x3[15:0];
        repeat (15) @(posedge CLK);
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_PAUSE);
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_BREAD);
        rd(OFS_STATUS, 32'h208, "dump busy");
        n = 0;
        while (ser_q.size() != 0 && n < 15000) begin
            @(posedge CLK);
            n++;
        end
        chk(n < 15000, 1'b1, "dump done");
        repeat (2) @(posedge CLK);
        rd(OFS_STATUS, 32'h201, "dump ready");
        xfer(1'b1, OFS_CMD, 32'h1 << CMD_FULL_POWER_RESET_CMD);
        xfer(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h0, "write ignored");
        rd(OFS_STATUS, 32'h10, "hold status");
        n = 0;
        do begin
            xfer(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdat[0] !== 1'b1 && n < 40);
        chk(n < 40, 1'b1, "ready again");
        rd(OFS_OUTSEL, 32'h0, "ports reset");
        xfer(1'b1, OFS_OUTSEL, 32'h0);
        chk(reloads, 1, "reload pulse");
        summarize();
    end
endmodule
`default_nettype wire
